/* File: pkg/fkwe_defs.vh */
/*
  Shared constants for the flash key, write and erase sequencer:
  register byte offsets, control field positions, key codes, reset
  values, array geometry and operation timing.
  Assumes a 10 MHz system clock and a 32-bit AHB-Lite register bus.
*/
`ifndef FKWE_DEFS_VH
`define FKWE_DEFS_VH

// Register byte offsets
`define FKWE_OFS_CTRL     8'h00
`define FKWE_OFS_KEY      8'h04
`define FKWE_OFS_ADDR     8'h08
`define FKWE_OFS_DMDATA   8'h0c
`define FKWE_OFS_CODE     8'h10
`define FKWE_OFS_STATUS   8'h14

// Program store control fields and reset value
`define FKWE_CTRL_WE_BIT  0
`define FKWE_CTRL_EE_BIT  1
`define FKWE_CTRL_RESET   2'h0

// Key codes, first then second
`define FKWE_KEY_FIRST    8'ha5
`define FKWE_KEY_SECOND   8'hf1

// Key lock states
`define FKWE_KS_IDLE      2'h0
`define FKWE_KS_FIRST     2'h1
`define FKWE_KS_OPEN      2'h2
`define FKWE_KS_LOCKED    2'h3

// Geometry: 4 KB flash in 512-byte pages, 256-byte data RAM
`define FKWE_FLASH_AW     12
`define FKWE_PAGE_AW      9
`define FKWE_PAGE_BYTES   512
`define FKWE_RAM_AW       8
`define FKWE_ERASED_BYTE  8'hff

// Timing: times in ns, cycle counts rounded up at the clock rate
`define FKWE_CLK_PERIOD_NS 100
`define FKWE_PROG_TIME_NS  20000
`define FKWE_ERASE_TIME_NS 60000
`define FKWE_PROG_CYCLES  ((`FKWE_PROG_TIME_NS + `FKWE_CLK_PERIOD_NS - 1) / `FKWE_CLK_PERIOD_NS)
`define FKWE_ERASE_CYCLES ((`FKWE_ERASE_TIME_NS + `FKWE_CLK_PERIOD_NS - 1) / `FKWE_CLK_PERIOD_NS)
`define FKWE_CNT_W        10

`endif

/* File: src/fkwe_key_lock.v */
/*
  Two-code key lock for software flash modification.
  Assumes single-cycle key write and attempt strobes from the
  register logic on the same clock, and a done pulse per operation.
*/
`default_nettype none
`include "fkwe_defs.vh"

module fkwe_key_lock (
  // Clock and reset
  input  wire       sys_clk,
  input  wire       rst,
  // Strobes from the register logic
  input  wire       keyWrite,
  input  wire [7:0] keyData,
  input  wire       opAttempt,
  input  wire       opDone,
  // Lock state
  output wire [1:0] keyState
);

  localparam [1:0] ST_IDLE   = `FKWE_KS_IDLE;
  localparam [1:0] ST_FIRST  = `FKWE_KS_FIRST;
  localparam [1:0] ST_OPEN   = `FKWE_KS_OPEN;
  localparam [1:0] ST_LOCKED = `FKWE_KS_LOCKED;

  reg  [1:0] state_ff;
  reg  [1:0] nxt_state;

  assign keyState = state_ff;

  // Next state; lockout only leaves through reset
  always @*
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE:
      begin
        if (keyWrite)
          nxt_state = (keyData == `FKWE_KEY_FIRST) ? ST_FIRST : ST_LOCKED;
        else if (opAttempt)
          nxt_state = ST_LOCKED;
      end
      ST_FIRST:
      begin
        if (keyWrite)
          nxt_state = (keyData == `FKWE_KEY_SECOND) ? ST_OPEN : ST_LOCKED;
        else if (opAttempt)
          nxt_state = ST_LOCKED;
      end
      ST_OPEN:
      begin
        if (keyWrite)
          nxt_state = ST_LOCKED;
        else if (opDone)
          nxt_state = ST_IDLE;
      end
      ST_LOCKED:
        nxt_state = ST_LOCKED;
      default:
        nxt_state = ST_LOCKED;
    endcase
  end

  // State register, cleared by system reset
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      state_ff <= ST_IDLE;
    else
      state_ff <= nxt_state;
  end

endmodule
`default_nettype wire

/* File: src/fkwe_flash_store.v */
/*
  Flash array with self-timed byte program and page erase.
  Assumes a start pulse only while idle; address and data are
  held internally from the start pulse on.
*/
`default_nettype none
`include "fkwe_defs.vh"

module fkwe_flash_store (
  // Clock and reset
  input  wire                      sys_clk,
  input  wire                      rst,
  // Operation request
  input  wire                      opStart,
  input  wire                      opErase,
  input  wire [`FKWE_FLASH_AW-1:0] opAddr,
  input  wire [7:0]                opData,
  // Operation status
  output wire                      busy,
  output wire                      done,
  // Code-memory read port
  input  wire [`FKWE_FLASH_AW-1:0] rdAddr,
  output wire [7:0]                rdData
);

  // Integer forms first, then cut to the counter width on purpose
  localparam integer           PROG_LAST_I  = `FKWE_PROG_CYCLES - 1;
  localparam integer           ERASE_LAST_I = `FKWE_ERASE_CYCLES - 1;
  localparam integer           PAGE_SIZE_I  = `FKWE_PAGE_BYTES;
  localparam [`FKWE_CNT_W-1:0] PROG_LAST    = PROG_LAST_I[`FKWE_CNT_W-1:0];
  localparam [`FKWE_CNT_W-1:0] ERASE_LAST   = ERASE_LAST_I[`FKWE_CNT_W-1:0];
  localparam [`FKWE_CNT_W-1:0] PAGE_SIZE    = PAGE_SIZE_I[`FKWE_CNT_W-1:0];

  reg  [7:0]                mem [0:(1<<`FKWE_FLASH_AW)-1];
  reg                       busy_ff;
  reg                       erase_ff;
  reg                       done_ff;
  reg  [`FKWE_CNT_W-1:0]    cnt_ff;
  reg  [`FKWE_FLASH_AW-1:0] addr_ff;
  reg  [7:0]                data_ff;
  wire                      lastCycle;
  wire                      sweep;

  assign busy      = busy_ff;
  assign done      = done_ff;
  assign rdData    = mem[rdAddr];
  assign lastCycle = busy_ff & (cnt_ff == (erase_ff ? ERASE_LAST : PROG_LAST));
  // Erase walks the page one byte per cycle inside the erase time
  assign sweep     = busy_ff & erase_ff & (cnt_ff < PAGE_SIZE);

  // Sequencer: hardware times every operation, no polling needed
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      busy_ff  <= 1'b0;
      erase_ff <= 1'b0;
      done_ff  <= 1'b0;
      cnt_ff   <= {`FKWE_CNT_W{1'b0}};
      addr_ff  <= {`FKWE_FLASH_AW{1'b0}};
      data_ff  <= 8'h00;
    end
    else
    begin
      done_ff <= lastCycle;
      if (opStart && !busy_ff)
      begin
        busy_ff  <= 1'b1;
        erase_ff <= opErase;
        cnt_ff   <= {`FKWE_CNT_W{1'b0}};
        addr_ff  <= opAddr;
        data_ff  <= opData;
      end
      else if (lastCycle)
        busy_ff <= 1'b0;
      else if (busy_ff)
        cnt_ff <= cnt_ff + 1'b1;
    end
  end

  // Array writes; contents are not touched by reset
  always @(posedge sys_clk)
  begin
    if (sweep)
      mem[{addr_ff[`FKWE_FLASH_AW-1:`FKWE_PAGE_AW], cnt_ff[`FKWE_PAGE_AW-1:0]}]
        <= `FKWE_ERASED_BYTE;
    else if (lastCycle && !erase_ff)
      mem[addr_ff] <= mem[addr_ff] & data_ff;
  end

endmodule
`default_nettype wire

/* File: src/fkwe_flash_key_write_erase.v */
/*
  Flash key, write and erase sequencer with an AHB-Lite register slave.
  Software sets the program store enables, writes the key codes and
  issues data-move writes and reads through the register window.
  Assumes a single AHB-Lite master on sys_clk; hreadyout is the bus
  hready. Data-move writes to flash stall the bus until done.
*/
`default_nettype none
`include "fkwe_defs.vh"

module fkwe_flash_key_write_erase (
  // Clock and reset
  input  wire        sys_clk,
  input  wire        rst,
  // AHB-Lite slave, address phase
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire        hready,
  // AHB-Lite slave, data phase
  input  wire [31:0] hwdata,
  output wire [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  // Status towards the core
  output wire        cpuStall,
  output wire        flashLockedOut
);

  // Bus phase tracking
  reg         dPhase_ff;
  reg         dWrite_ff;
  reg  [7:0]  dAddr_ff;
  reg         waitOp_ff;
  reg         hreadyout_ff;
  reg  [31:0] hrdata_ff;
  reg         hresp_ff;

  // Software-visible control and data-move address; stall and lockout flags for the core
  reg         wrEnable_ff;
  reg         erEnable_ff;
  reg  [15:0] dmAddr_ff;
  reg         stall_ff;
  reg         lockedOut_ff;

  // External data RAM reached by data-move cycles
  reg  [7:0]  dataRam [0:(1<<`FKWE_RAM_AW)-1];

  wire        addrTake;
  wire        busWrite;
  wire        busRead;
  wire        keyWrite;
  wire        dmWrite;
  wire        opAttempt;
  wire        opStart;
  wire        ramWrite;
  wire [1:0]  keyState;
  wire        flashBusy;
  wire        flashDone;
  wire [7:0]  codeByte;
  reg  [31:0] nxt_rdata;

  // Control reset value, split per bit below
  localparam [1:0] CTRL_RST = `FKWE_CTRL_RESET;

  // Register address decode, word offset within the window
  function is_reg;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      is_reg = (addr[7:2] == ofs[7:2]);
    end
  endfunction

  assign hrdata         = hrdata_ff;
  assign hreadyout      = hreadyout_ff;
  assign hresp          = hresp_ff;
  assign cpuStall       = stall_ff;
  assign flashLockedOut = lockedOut_ff;

  // A transfer starts only on NONSEQ or SEQ with the bus ready
  assign addrTake = hsel & htrans[1] & hready;
  assign busWrite = dPhase_ff & dWrite_ff;
  assign busRead  = dPhase_ff & !dWrite_ff;

  // Strobes valid in the data phase, when hwdata stands
  assign keyWrite  = busWrite & is_reg(dAddr_ff, `FKWE_OFS_KEY);
  assign dmWrite   = busWrite & is_reg(dAddr_ff, `FKWE_OFS_DMDATA);
  assign opAttempt = dmWrite & wrEnable_ff;
  assign opStart   = opAttempt & (keyState == `FKWE_KS_OPEN);
  assign ramWrite  = dmWrite & !wrEnable_ff;

  // Key lock state machine
  fkwe_key_lock u_key_lock (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .keyWrite  (keyWrite),
    .keyData   (hwdata[7:0]),
    .opAttempt (opAttempt),
    .opDone    (flashDone),
    .keyState  (keyState)
  );

  // Flash array and its self-timed sequencer
  fkwe_flash_store u_flash_store (
    .sys_clk (sys_clk),
    .rst     (rst),
    .opStart (opStart),
    .opErase (erEnable_ff),
    .opAddr  (dmAddr_ff[`FKWE_FLASH_AW-1:0]),
    .opData  (hwdata[7:0]),
    .busy    (flashBusy),
    .done    (flashDone),
    .rdAddr  (dmAddr_ff[`FKWE_FLASH_AW-1:0]),
    .rdData  (codeByte)
  );

  // Read mux; data-move reads never see flash
  always @*
  begin
    nxt_rdata = 32'h00000000;
    if (is_reg(dAddr_ff, `FKWE_OFS_CTRL))
    begin
      nxt_rdata[`FKWE_CTRL_WE_BIT] = wrEnable_ff;
      nxt_rdata[`FKWE_CTRL_EE_BIT] = erEnable_ff;
    end
    else if (is_reg(dAddr_ff, `FKWE_OFS_KEY))
      nxt_rdata[1:0] = keyState;
    else if (is_reg(dAddr_ff, `FKWE_OFS_ADDR))
      nxt_rdata[15:0] = dmAddr_ff;
    else if (is_reg(dAddr_ff, `FKWE_OFS_DMDATA))
      nxt_rdata[7:0] = dataRam[dmAddr_ff[`FKWE_RAM_AW-1:0]];
    else if (is_reg(dAddr_ff, `FKWE_OFS_CODE))
      nxt_rdata[7:0] = codeByte;
    else if (is_reg(dAddr_ff, `FKWE_OFS_STATUS))
    begin
      nxt_rdata[0]   = flashBusy;
      nxt_rdata[1]   = (keyState == `FKWE_KS_LOCKED);
      nxt_rdata[3:2] = keyState;
    end
  end

  // Bus slave: one wait state per transfer, more while flash works.
  // Holding hready low is how the core's fetches are stalled.
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      dPhase_ff    <= 1'b0;
      dWrite_ff    <= 1'b0;
      dAddr_ff     <= 8'h00;
      waitOp_ff    <= 1'b0;
      hreadyout_ff <= 1'b1;
      hrdata_ff    <= 32'h00000000;
      hresp_ff     <= 1'b0;
    end
    else
    begin
      hresp_ff <= 1'b0;
      if (addrTake)
      begin
        dPhase_ff    <= 1'b1;
        dWrite_ff    <= hwrite;
        dAddr_ff     <= haddr[7:0];
        hreadyout_ff <= 1'b0;
      end
      else if (dPhase_ff)
      begin
        dPhase_ff <= 1'b0;
        if (busRead)
          hrdata_ff <= nxt_rdata;
        if (opStart)
          waitOp_ff <= 1'b1;
        else
          hreadyout_ff <= 1'b1;
      end
      else if (waitOp_ff && flashDone)
      begin
        waitOp_ff    <= 1'b0;
        hreadyout_ff <= 1'b1;
      end
    end
  end

  // Control register and data-move address
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      wrEnable_ff <= CTRL_RST[`FKWE_CTRL_WE_BIT];
      erEnable_ff <= CTRL_RST[`FKWE_CTRL_EE_BIT];
      dmAddr_ff   <= 16'h0000;
    end
    else if (busWrite)
    begin
      // Only software changes the enables; operations leave them be
      if (is_reg(dAddr_ff, `FKWE_OFS_CTRL))
      begin
        wrEnable_ff <= hwdata[`FKWE_CTRL_WE_BIT];
        erEnable_ff <= hwdata[`FKWE_CTRL_EE_BIT];
      end
      if (is_reg(dAddr_ff, `FKWE_OFS_ADDR))
        dmAddr_ff <= hwdata[15:0];
    end
  end

  // Stall flag and lockout indicator for the core
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      stall_ff     <= 1'b0;
      lockedOut_ff <= 1'b0;
    end
    else
    begin
      if (opStart)
        stall_ff <= 1'b1;
      else if (flashDone)
        stall_ff <= 1'b0;
      lockedOut_ff <= (keyState == `FKWE_KS_LOCKED);
    end
  end

  // Data RAM write port; no reset on the array
  always @(posedge sys_clk)
  begin
    if (ramWrite)
      dataRam[dmAddr_ff[`FKWE_RAM_AW-1:0]] <= hwdata[7:0];
  end

endmodule
`default_nettype wire

/* File: verif/fkwe_flash_key_write_erase_chk.sv */
/*
  Bus, stall and lockout checker for the flash sequencer top.
  Assumes one AHB-Lite master with hready tied to hreadyout.
*/
`default_nettype none
module fkwe_flash_key_write_erase_chk (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        rst,
  // Bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Status
  input wire logic        cpuStall,
  input wire logic        flashLockedOut
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  logic [9:0] stallCnt_ff;
  logic [9:0] nxt_stallCnt;
  logic       take;
  // Stall length, cleared between operations so each op is measured alone
  assign nxt_stallCnt = cpuStall ? stallCnt_ff + 10'h1 : 10'h0;
  assign take = hsel & htrans[1] & hready;
  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
      stallCnt_ff <= 10'h0;
    else
      stallCnt_ff <= nxt_stallCnt;

  a_resp_okay: assert property (!hresp)
    else $error("bus response not okay");
  a_one_wait: assert property (take && !(hwrite && haddr[7:2] == 6'h03) |=> !hreadyout ##1 hreadyout)
    else $error("plain transfer not one wait state");
  a_stall_bus: assert property ($rose(cpuStall) |-> !hreadyout [*8])
    else $error("bus not held during stall");
  a_stall_len: assert property ($fell(cpuStall) |-> stallCnt_ff inside {[198:203], [598:603]})
    else $error("stall length wrong");
  a_stall_resume: assert property ($fell(cpuStall) |-> ##[0:2] hreadyout)
    else $error("bus not resumed after stall");
  a_read_quiet: assert property (take && !hwrite |=> !$rose(cpuStall) [*3])
    else $error("read started flash operation");
  a_lock_sticky: assert property (flashLockedOut |=> flashLockedOut)
    else $error("lockout released without reset");
  a_lock_no_op: assert property (flashLockedOut |-> !$rose(cpuStall))
    else $error("flash operation while locked out");
endmodule

bind fkwe_flash_key_write_erase fkwe_flash_key_write_erase_chk fkwe_flash_key_write_erase_chk_inst (
  .sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .cpuStall(cpuStall), .flashLockedOut(flashLockedOut)
);
`default_nettype wire

/* File: verif/fkwe_cpu_master.sv */
/*
  CPU core model: single-word AHB-Lite master for register access.
  Assumes hready is the only slave's hreadyout; waits without limit.
*/
`default_nettype none
module fkwe_cpu_master (
  // Clock and slave answer
  input  wire logic        sys_clk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  // Request
  output var  logic        hsel,
  output var  logic [31:0] haddr,
  output var  logic [1:0]  htrans,
  output var  logic        hwrite,
  output var  logic [2:0]  hsize,
  output var  logic [31:0] hwdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end

  // One transfer; released address and data show inverted junk, never stale values; hsel and htrans go idle
  task automatic xfer(input logic wr, input logic [7:0] ofs, input logic [31:0] wd,
                      output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h0, ofs};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge sys_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    haddr <= ~haddr;
    hwdata <= wr ? wd : ~hwdata;
    do @(posedge sys_clk); while (hready !== 1'b1);
    rd = hrdata;
    hwdata <= ~wd;
  endtask
endmodule
`default_nettype wire

/* File: verif/fkwe_flash_key_write_erase_tb_top.sv */
/*
  Testbench for the flash sequencer: software sequences over the bus.
  Assumes the register map and timing of the shared definitions header.
*/
`default_nettype none
`include "fkwe_defs.vh"
module fkwe_flash_key_write_erase_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic             sys_clk = 1'b0;
  logic             rst = 1'b1;
  int               badCount = 0;
  int               checksDone = 0;
  logic [7:0]       keySeq [4][3] = '{'{8'h00, 8'h00, 8'h00}, '{8'hf1, 8'ha5, 8'h00},
                                      '{8'ha5, 8'ha5, 8'h00}, '{8'ha5, 8'hf1, 8'ha5}};
  int               keyLen [4] = '{0, 2, 2, 3};
  wire logic        hsel;
  wire logic [31:0] haddr;
  wire logic [1:0]  htrans;
  wire logic        hwrite;
  wire logic [2:0]  hsize;
  wire logic [31:0] hwdata;
  wire logic [31:0] hrdata;
  wire logic        hreadyout;
  wire logic        hresp;
  wire logic        cpuStall;
  wire logic        flashLockedOut;

  always #50 sys_clk = ~sys_clk;

  fkwe_flash_key_write_erase fkwe_flash_key_write_erase_inst (
    .sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .cpuStall(cpuStall),
    .flashLockedOut(flashLockedOut));
  fkwe_cpu_master fkwe_cpu_master_inst (
    .sys_clk(sys_clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checksDone++;
    if (got !== exp)
    begin
      badCount++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
    logic [31:0] unused;
    fkwe_cpu_master_inst.xfer(1'b1, ofs, d, unused);
  endtask
  task automatic rchk(input string what, input logic [7:0] ofs, input logic [31:0] exp);
    logic [31:0] v;
    fkwe_cpu_master_inst.xfer(1'b0, ofs, 32'h0, v);
    chk(what, exp, v);
  endtask
  // Code-memory read of one flash byte
  task automatic code(input logic [11:0] a, input logic [7:0] exp);
    wr(`FKWE_OFS_ADDR, {20'h0, a});
    rchk("code byte", `FKWE_OFS_CODE, {24'h0, exp});
  endtask
  task automatic pageErased(input logic [11:0] base);
    for (int i = 0; i < `FKWE_PAGE_BYTES; i++)
      code(base + i[11:0], `FKWE_ERASED_BYTE);
  endtask
  // Key codes (skipped if gap < 0) with a pause of gap cycles between them, then one data-move write
  task automatic flashOp(input logic [1:0] ctrl, input logic [11:0] a, input logic [7:0] d,
                         input int gap, input logic stall);
    wr(`FKWE_OFS_CTRL, {30'h0, ctrl});
    if (gap >= 0)
    begin
      wr(`FKWE_OFS_KEY, {24'h0, `FKWE_KEY_FIRST});
      repeat (gap) @(posedge sys_clk);
      wr(`FKWE_OFS_KEY, {24'h0, `FKWE_KEY_SECOND});
    end
    wr(`FKWE_OFS_ADDR, {20'h0, a});
    fork
      wr(`FKWE_OFS_DMDATA, {24'h0, d});
      begin
        repeat (20) @(posedge sys_clk);
        chk("stall", {31'h0, stall}, {31'h0, cpuStall});
      end
    join
  endtask
  task automatic doReset();
    rst <= 1'b1;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
  endtask
  task automatic finalReport();
    $display("checks %0d mismatches %0d", checksDone, badCount);
    if (badCount == 0 && checksDone > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    doReset();
    rchk("ctrl reset", `FKWE_OFS_CTRL, 32'h0);
    rchk("key reset", `FKWE_OFS_KEY, {30'h0, `FKWE_KS_IDLE});
    rchk("status reset", `FKWE_OFS_STATUS, 32'h0);
    wr(8'h18, 32'hffffffff);
    rchk("unmapped", 8'h18, 32'h0);
    $display("test registers done");
    flashOp(2'h3, 12'h3ff, 8'h00, 40, 1'b1);
    rchk("key relock", `FKWE_OFS_KEY, {30'h0, `FKWE_KS_IDLE});
    rchk("ctrl kept", `FKWE_OFS_CTRL, 32'h3);
    pageErased(12'h200);
    flashOp(2'h1, 12'h200, 8'h5a, 0, 1'b1);
    code(12'h200, 8'h5a);
    code(12'h201, `FKWE_ERASED_BYTE);
    flashOp(2'h1, 12'h200, 8'hf0, 0, 1'b1);
    code(12'h200, 8'h50);
    flashOp(2'h3, 12'h010, 8'h00, 0, 1'b1);
    pageErased(12'h000);
    code(12'h200, 8'h50);
    $display("test erase and program done");
    flashOp(2'h0, 12'h220, 8'h3c, -1, 1'b0);
    code(12'h220, `FKWE_ERASED_BYTE);
    wr(`FKWE_OFS_CTRL, 32'h1);
    rchk("ram read", `FKWE_OFS_DMDATA, 32'h3c);
    $display("test ram path done");
    for (int c = 0; c < 4; c++)
    begin
      doReset();
      chk("lock after reset", 32'h0, {31'h0, flashLockedOut});
      for (int k = 0; k < keyLen[c]; k++)
        wr(`FKWE_OFS_KEY, {24'h0, keySeq[c][k]});
      flashOp(2'h1, 12'h200, 8'h00, (c == 0) ? -1 : 0, 1'b0);
      chk("locked out", 32'h1, {31'h0, flashLockedOut});
      rchk("key locked", `FKWE_OFS_KEY, {30'h0, `FKWE_KS_LOCKED});
      rchk("status locked", `FKWE_OFS_STATUS, {28'h0, `FKWE_KS_LOCKED, 2'h2});
      code(12'h200, 8'h50);
    end
    $display("test lockout done");
    finalReport();
  end

  // Watchdog, about two and a half times the expected run
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    badCount++;
    finalReport();
  end
endmodule
`default_nettype wire
